/* File: sim/rssup_partner.sv */
// Far-side model: reset pin with pull-up and supply comparator levels
`timescale 1ns/1ps
module rssup_partner (
	// Bench commands: b0 pin low, b11 logic-driven reset, b10..b1 comparator and power-state levels
	input wire logic [11:0] cmd_i,
	// Pin and analog levels toward the supervisor
	output logic ext_reset_n_o,
	output logic [10:0] level_o
);
	////////////////////////////////////////////////////////////////////////////
	// Released pin goes high through the pull-up, so it never reads unknown
	assign ext_reset_n_o = cmd_i[0] ? 1'b0 : 1'b1;
	// Comparator outputs are steady levels chosen by the bench
	assign level_o = cmd_i[11:1];
endmodule

/* File: sim/rssup_props.sv */
// Concurrent port checks of the reset supervisor
`timescale 1ns/1ps
module rssup_props
	import rssup_pkg::*;
(
	// Clock, power-on reset and APB
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	// Supervisor pins
	input wire logic ext_reset_n_i,
	input wire logic prec_dig_trip_i,
	input wire logic sleep_i,
	input wire logic hibernate_i,
	input wire logic buzz_i,
	input wire logic sys_reset_n_o,
	input wire logic por_mon_enable_o,
	input wire logic prec_dig_enable_o,
	input wire logic prec_ana_enable_o,
	input wire logic monitor_enable_o,
	input wire logic monitor_irq_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	logic [2:0] rel_cnt_ff;
	////////////////////////////////////////////////////////////////////////////
	// Edges since power-on release; saturates so it never wraps into a false fail
	always_ff @(posedge clk_sys_i or negedge resetn_i)
		if (!resetn_i)
			rel_cnt_ff <= 3'h0;
		else if (rel_cnt_ff != 3'h7)
			rel_cnt_ff <= rel_cnt_ff + 3'h1;
	// Committed write that sets the software bit with its disable cleared
	sequence s_sw_write;
		sys_reset_n_o && psel_i && penable_i && pready_o && pwrite_i
			&& paddr_i == RSSUP_CTRL_OFS && pwdata_i[1:0] == 2'h1;
	endsequence
	// Two cycles of sleep without buzz, or of hibernate
	sequence s_deep;
		(hibernate_i || sleep_i && !buzz_i) [*2];
	endsequence
	////////////////////////////////////////////////////////////////////////////
	a_pin_reset: assert property (!ext_reset_n_i |=> !sys_reset_n_o)
		else $error("pin low did not hold reset");
	a_por_width: assert property (sys_reset_n_o |-> rel_cnt_ff > RSSUP_POR_MIN_CYC)
		else $error("power-on pulse too short");
	a_por_handoff: assert property (por_mon_enable_o |-> !prec_dig_enable_o && !prec_ana_enable_o)
		else $error("precise reset on before handoff");
	a_mon_gate: assert property (!monitor_enable_o |-> !monitor_irq_o)
		else $error("monitor interrupt before power-on done");
	a_prec_reset: assert property (prec_dig_trip_i && prec_dig_enable_o |=> !sys_reset_n_o)
		else $error("precise trip gave no reset");
	a_deep_off: assert property (s_deep |=> !prec_dig_enable_o && !prec_ana_enable_o)
		else $error("precise reset on in deep sleep");
	a_dig_on: assert property (((!sleep_i || buzz_i) && !hibernate_i && !por_mon_enable_o) [*2]
		|=> prec_dig_enable_o)
		else $error("digital precise reset off while awake");
	a_irq_sleep: assert property (sleep_i [*2] |-> !monitor_irq_o)
		else $error("interrupt presented during sleep");
	a_sw_reset: assert property (s_sw_write |-> ##[1:4] !sys_reset_n_o)
		else $error("software bit gave no reset");
	a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("access phase not answered");
endmodule
bind rssup_top rssup_props rssup_props_inst (.clk_sys_i, .resetn_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pready_o, .ext_reset_n_i, .prec_dig_trip_i, .sleep_i,
	.hibernate_i, .buzz_i, .sys_reset_n_o, .por_mon_enable_o, .prec_dig_enable_o,
	.prec_ana_enable_o, .monitor_enable_o, .monitor_irq_o);

/* File: sim/testbench.sv */
// Self-checking bench of the reset supervisor over APB
`timescale 1ns/1ps
module testbench;
	import rssup_pkg::*;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [11:0] pcmd = 12'h004;
	logic [31:0] prdata, q;
	logic [10:0] lvl;
	logic [3:0] dlev, alev;
	logic pready, pslverr, eflag, pin_n, srst_n, por_en, pd_en, pa_en, mon_en, osc_en, wake, irq;
	logic [31:0] mw [3] = '{32'h10F, 32'h200, 32'h400};
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	rssup_partner rssup_partner_inst (.cmd_i(pcmd), .ext_reset_n_o(pin_n), .level_o(lvl));
	rssup_top #(.WDOG_PERIOD_RST(16'h0010)) rssup_top_inst (.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .ext_reset_n_i(pin_n), .logic_driven_reset_i(lvl[10]),
		.supply_ramping_i(lvl[0]), .dig_supply_stable_i(lvl[1]), .prec_dig_trip_i(lvl[2]),
		.prec_ana_trip_i(lvl[3]), .dig_low_trip_i(lvl[4]), .ana_low_trip_i(lvl[5]),
		.ana_high_trip_i(lvl[6]), .sleep_i(lvl[7]), .hibernate_i(lvl[8]), .buzz_i(lvl[9]),
		.sys_reset_n_o(srst_n), .por_mon_enable_o(por_en), .prec_dig_enable_o(pd_en),
		.prec_ana_enable_o(pa_en), .monitor_enable_o(mon_en), .dig_low_level_o(dlev),
		.ana_low_level_o(alev), .main_oscillator_en_o(osc_en), .wake_req_o(wake),
		.monitor_irq_o(irq));
	////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do
			@(posedge clk_sys_i);
		while (pready !== 1'b1);
		q = prdata;
		eflag = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// Bounded wait for the system reset level
	task automatic wsr(input logic v);
		for (int i = 0; i < 64 && srst_n !== v; i++)
			@(posedge clk_sys_i);
		chk(32'(srst_n), 32'(v));
	endtask
	// Raise one source, see reset held, release, check and clear the cause
	task automatic trip(input int b, input logic [31:0] st, input logic [31:0] m);
		repeat (3) @(posedge clk_sys_i);
		pcmd[b] <= 1'b1;
		wsr(1'b0);
		repeat (8) @(posedge clk_sys_i);
		// Pin-mode bit is itself reset, so a logic-driven reset ends on its own
		if (m == 32'h3FF)
			chk(32'(srst_n), 32'(b == 11));
		pcmd[b] <= 1'b0;
		wsr(1'b1);
		apb(1'b0, RSSUP_STAT_OFS, 32'h0);
		chk(q & m, st);
		apb(1'b1, RSSUP_STAT_OFS, 32'h3FF);
	endtask
	// A gated source must not reset
	task automatic nohit(input int b);
		repeat (3) @(posedge clk_sys_i);
		pcmd[b] <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		chk(32'(srst_n), 32'h1);
		pcmd[b] <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
		forever #25 clk_sys_i = ~clk_sys_i;
	// Cycle ceiling; the whole sequence needs well under a tenth of it
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			summarize();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		wsr(1'b1);
		rd(RSSUP_CTRL_OFS, 32'h4);
		rd(RSSUP_MON_OFS, 32'h0);
		rd(RSSUP_STAT_OFS, 32'h0);
		rd(RSSUP_WDCTL_OFS, 32'h0);
		rd(RSSUP_WDPER_OFS, 32'h10);
		apb(1'b0, 8'h14, 32'h0);
		chk(32'(eflag), 32'h1);
		// Pin, precise and software sources
		apb(1'b1, RSSUP_MON_OFS, 32'h155);
		trip(0, 32'h2, 32'h3FF);
		rd(RSSUP_MON_OFS, 32'h0);
		trip(3, 32'h1, 32'h3FF);
		apb(1'b1, RSSUP_CTRL_OFS, 32'h0);
		nohit(4);
		apb(1'b1, RSSUP_CTRL_OFS, 32'h4);
		trip(4, 32'h1, 32'h3FF);
		nohit(11);
		apb(1'b1, RSSUP_CTRL_OFS, 32'h8);
		trip(11, 32'h4, 32'h3FF);
		apb(1'b1, RSSUP_CTRL_OFS, 32'h7);
		repeat (6) @(posedge clk_sys_i);
		chk(32'(srst_n), 32'h1);
		apb(1'b1, RSSUP_CTRL_OFS, 32'h5);
		wsr(1'b0);
		wsr(1'b1);
		rd(RSSUP_CTRL_OFS, 32'h4);
		rd(RSSUP_STAT_OFS, 32'h10);
		apb(1'b1, RSSUP_STAT_OFS, 32'h3FF);
		// Precise reset only during buzz while sleeping
		pcmd[8] <= 1'b1;
		nohit(3);
		pcmd[10] <= 1'b1;
		trip(3, 32'h1, 32'h3FF);
		// Hibernate keeps it off even with a buzz request
		pcmd[10:8] <= 3'h6;
		nohit(3);
		pcmd[10:8] <= 3'h0;
		// Monitor levels, interrupts and reset modes
		apb(1'b1, RSSUP_MON_OFS, 32'h0F0);
		@(posedge clk_sys_i);
		chk(32'({dlev, alev}), 32'h0F);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, RSSUP_MON_OFS, mw[i]);
			pcmd[5 + i] <= 1'b1;
			repeat (5) @(posedge clk_sys_i);
			chk(32'(irq), 32'h1);
			pcmd[5 + i] <= 1'b0;
			rd(RSSUP_STAT_OFS, 32'h80 << i);
			apb(1'b1, RSSUP_STAT_OFS, 32'h3FF);
			repeat (3) @(posedge clk_sys_i);
			chk(32'(irq), 32'h0);
		end
		pcmd[8:7] <= 2'b11;
		repeat (5) @(posedge clk_sys_i);
		chk(32'({wake, irq}), 32'h2);
		pcmd[8:7] <= 2'b00;
		repeat (3) @(posedge clk_sys_i);
		chk(32'(irq), 32'h1);
		apb(1'b1, RSSUP_STAT_OFS, 32'h3FF);
		apb(1'b1, RSSUP_MON_OFS, 32'h900);
		trip(5, 32'h20, 32'h20);
		apb(1'b1, RSSUP_MON_OFS, 32'h1200);
		trip(6, 32'h40, 32'h40);
		// Watchdog kept alive by kicks, then left to expire
		apb(1'b1, RSSUP_WDCTL_OFS, 32'h1);
		repeat (5)
		begin
			repeat (8) @(posedge clk_sys_i);
			apb(1'b1, RSSUP_WDCTL_OFS, 32'h3);
		end
		chk(32'(srst_n), 32'h1);
		wsr(1'b0);
		wsr(1'b1);
		rd(RSSUP_WDCTL_OFS, 32'h1);
		rd(RSSUP_STAT_OFS, 32'h8);
		// Power-on again with a slow supply ramp
		resetn_i <= 1'b0;
		pcmd[2:1] <= 2'b01;
		repeat (3) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		chk(32'({srst_n, por_en, pd_en, pa_en, osc_en, mon_en}), 32'h10);
		pcmd[2:1] <= 2'b10;
		wsr(1'b1);
		repeat (3) @(posedge clk_sys_i);
		chk(32'({por_en, pd_en, pa_en, osc_en, mon_en}), 32'h0F);
		rd(RSSUP_STAT_OFS, 32'h0);
		rd(RSSUP_WDCTL_OFS, 32'h0);
		summarize();
	end
endmodule

/* File: verilog/rssup_pkg.sv */
// Package with register map, field layout and timing constants of the reset supervisor
package rssup_pkg;
	// Register byte offsets
	localparam logic [7:0] RSSUP_CTRL_OFS = 8'h00;
	localparam logic [7:0] RSSUP_MON_OFS = 8'h04;
	localparam logic [7:0] RSSUP_STAT_OFS = 8'h08;
	localparam logic [7:0] RSSUP_WDCTL_OFS = 8'h0C;
	localparam logic [7:0] RSSUP_WDPER_OFS = 8'h10;
	// Control register fields
	localparam int RSSUP_CTRL_SWRST = 0;
	localparam int RSSUP_CTRL_SWDIS = 1;
	localparam int RSSUP_CTRL_ANAEN = 2;
	localparam int RSSUP_CTRL_PINMODE = 3;
	localparam logic [3:0] RSSUP_CTRL_RST = 4'h4;
	// Monitor register fields
	localparam int RSSUP_MON_DLVL_LSB = 0;
	localparam int RSSUP_MON_ALVL_LSB = 4;
	localparam int RSSUP_MON_DEN = 8;
	localparam int RSSUP_MON_AEN = 9;
	localparam int RSSUP_MON_HEN = 10;
	localparam int RSSUP_MON_DRST = 11;
	localparam int RSSUP_MON_ARST = 12;
	localparam logic [12:0] RSSUP_MON_RST = 13'h0000;
	// Status register bits
	localparam int RSSUP_ST_PREC = 0;
	localparam int RSSUP_ST_PIN = 1;
	localparam int RSSUP_ST_LOGIC = 2;
	localparam int RSSUP_ST_WDOG = 3;
	localparam int RSSUP_ST_SOFT = 4;
	localparam int RSSUP_ST_DLVR = 5;
	localparam int RSSUP_ST_ALVR = 6;
	localparam int RSSUP_ST_DLIRQ = 7;
	localparam int RSSUP_ST_ALIRQ = 8;
	localparam int RSSUP_ST_AHIRQ = 9;
	localparam int RSSUP_ST_W = 10;
	localparam logic [9:0] RSSUP_IRQ_MASK = 10'h380;
	// Watchdog control fields
	localparam int RSSUP_WD_EN = 0;
	localparam int RSSUP_WD_KICK = 1;
	localparam logic [15:0] RSSUP_WDPER_RST = 16'hFFFF;
	// Timing
	localparam int RSSUP_CLK_PERIOD_NS = 50;
	localparam int RSSUP_POR_MIN_NS = 100;
	localparam int RSSUP_POR_MIN_CYC_I =
		(RSSUP_POR_MIN_NS + RSSUP_CLK_PERIOD_NS - 1) / RSSUP_CLK_PERIOD_NS;
	localparam logic [2:0] RSSUP_POR_MIN_CYC = 3'(RSSUP_POR_MIN_CYC_I);
	localparam logic [2:0] RSSUP_HOLD_CYC = RSSUP_POR_MIN_CYC;
endpackage

/* File: verilog/rssup_top.sv */
// Reset and supply supervisor with APB register slave
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - Reset pin, watchdog and precise low-voltage reset each force a system reset.
// - A supply below its enabled precise-reset level produces a reset, except in sleep and hibernate outside sleep buzzes.
// - Supply monitors can raise a processor interrupt before reset thresholds.
// - Reset pin held low keeps the device in reset, like power-on.
// - Reset pin works in sleep and hibernate; undriven pin reads inactive.
// - Watchdog not serviced within its period issues a system reset.
// - Setting the software reset bit causes a power-on-like reset.
// - A disable bit stops the software reset bit from resetting.
// - System reset returns processor, peripherals and registers to reset state, except status and watchdog enable.
// - Status keeps reset and monitor interrupt causes; power-on or writing ones clears them.
// - Power-on reset pulse lasts at least 100 ns, longer while supplies ramp.
// - Stable digital supply hands over to precise reset; oscillator starts after.
// - Precise low-voltage trip resets like power-on but keeps status and watchdog enable.
// - Digital precise reset cannot be disabled; analog part follows regulator.
// - Precise reset off in sleep and hibernate, on during sleep buzzes.
// - Low-voltage trip levels 1.70 V to 5.45 V in 250 mV steps.
// - Each low-voltage monitor can reset instead of interrupting.
// - Voltage monitors stay disabled until power-on reset completes.
// - Monitor interrupt during a sleep buzz wakes first, then is presented.
// - Logic-driven reset through the pin in reset mode acts like power-on.
// - Power-on disables watchdog; once enabled it stays until power-on.
module rssup_top #(
	parameter logic [15:0] WDOG_PERIOD_RST = rssup_pkg::RSSUP_WDPER_RST
) (
	// Clock and power-on reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Reset sources
	input wire logic ext_reset_n_i,
	input wire logic logic_driven_reset_i,
	// Analog supply comparators and power state
	input wire logic supply_ramping_i,
	input wire logic dig_supply_stable_i,
	input wire logic prec_dig_trip_i,
	input wire logic prec_ana_trip_i,
	input wire logic dig_low_trip_i,
	input wire logic ana_low_trip_i,
	input wire logic ana_high_trip_i,
	input wire logic sleep_i,
	input wire logic hibernate_i,
	input wire logic buzz_i,
	// Supervisor outputs
	output logic sys_reset_n_o,
	output logic por_mon_enable_o,
	output logic prec_dig_enable_o,
	output logic prec_ana_enable_o,
	output logic monitor_enable_o,
	output logic [3:0] dig_low_level_o,
	output logic [3:0] ana_low_level_o,
	output logic main_oscillator_en_o,
	output logic wake_req_o,
	output logic monitor_irq_o
);
	import rssup_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [2:0] por_cnt;
		logic por_done;
		logic por_mon_on;
		logic osc_en;
		logic sys_rst;
		logic [2:0] hold_cnt;
		logic [3:0] ctrl;
		logic [12:0] mon;
		logic [RSSUP_ST_W-1:0] stat;
		logic wdog_en;
		logic [15:0] wdog_cnt;
		logic [15:0] wdog_per;
		logic prec_den;
		logic prec_aen;
		logic wake_req;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} rssup_state_type;

	rssup_state_type st_ff;
	rssup_state_type nxt_st;

	////////////////////////////////////////////////////////////////////////////////
	// Source qualification

	logic bus_wr;
	logic bus_rd_phase;
	logic prec_on;
	logic prec_dig;
	logic prec_ana;
	logic pin_rst;
	logic drv_rst;
	logic dlv_trip;
	logic alv_trip;
	logic ahv_trip;
	logic dlv_rst;
	logic alv_rst;
	logic wdog_trip;
	logic sw_rst;
	logic level_src;
	logic pulse_src;
	logic [RSSUP_ST_W-1:0] stat_set;
	logic [RSSUP_ST_W-1:0] stat_clr;

	// A write lands only on the edge that completes the access phase
	assign bus_wr = psel_i & penable_i & st_ff.pready & pwrite_i;
	assign bus_rd_phase = psel_i & penable_i & ~st_ff.pready;

	// Precise reset is gated off in low power states except during buzz windows of sleep without hibernate
	assign prec_on = ~(sleep_i | hibernate_i) | (sleep_i & ~hibernate_i & buzz_i);
	assign prec_dig = st_ff.prec_den & prec_dig_trip_i;
	assign prec_ana = st_ff.prec_aen & prec_ana_trip_i;
	// The pad pull-up keeps an undriven pin high, so low always means reset
	assign pin_rst = ~ext_reset_n_i;
	assign drv_rst = st_ff.ctrl[RSSUP_CTRL_PINMODE] & logic_driven_reset_i;

	// Monitors are ignored until power-on has completed
	assign dlv_trip = st_ff.por_done & st_ff.mon[RSSUP_MON_DEN] & dig_low_trip_i;
	assign alv_trip = st_ff.por_done & st_ff.mon[RSSUP_MON_AEN] & ana_low_trip_i;
	assign ahv_trip = st_ff.por_done & st_ff.mon[RSSUP_MON_HEN] & ana_high_trip_i;
	assign dlv_rst = dlv_trip & st_ff.mon[RSSUP_MON_DRST];
	assign alv_rst = alv_trip & st_ff.mon[RSSUP_MON_ARST];

	// Watchdog expires once its count reaches the programmed period
	assign wdog_trip = st_ff.wdog_en & ~st_ff.sys_rst & (st_ff.wdog_cnt >= st_ff.wdog_per);
	assign sw_rst = st_ff.ctrl[RSSUP_CTRL_SWRST] & ~st_ff.ctrl[RSSUP_CTRL_SWDIS];

	// Level sources hold reset themselves; pulse sources are stretched by the hold counter
	assign level_src = prec_dig | prec_ana | pin_rst | drv_rst | dlv_rst | alv_rst;
	assign pulse_src = wdog_trip | sw_rst;

	// Cause flags: set wins over a same-cycle clear
	always_comb
	begin
		stat_set = '0;
		stat_set[RSSUP_ST_PREC] = prec_dig | prec_ana;
		stat_set[RSSUP_ST_PIN] = pin_rst;
		stat_set[RSSUP_ST_LOGIC] = drv_rst;
		stat_set[RSSUP_ST_WDOG] = wdog_trip;
		stat_set[RSSUP_ST_SOFT] = sw_rst;
		stat_set[RSSUP_ST_DLVR] = dlv_rst;
		stat_set[RSSUP_ST_ALVR] = alv_rst;
		stat_set[RSSUP_ST_DLIRQ] = dlv_trip & ~st_ff.mon[RSSUP_MON_DRST];
		stat_set[RSSUP_ST_ALIRQ] = alv_trip & ~st_ff.mon[RSSUP_MON_ARST];
		stat_set[RSSUP_ST_AHIRQ] = ahv_trip;
		stat_clr = '0;
		if (bus_wr && paddr_i == RSSUP_STAT_OFS)
		begin
			stat_clr = pwdata_i[RSSUP_ST_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		nxt_st = st_ff;

		// Minimum power-on pulse, stretched while supplies still ramp
		if (!st_ff.por_done)
		begin
			if (supply_ramping_i)
			begin
				nxt_st.por_cnt = '0;
			end
			else if (st_ff.por_cnt < RSSUP_POR_MIN_CYC - 3'h1)
			begin
				nxt_st.por_cnt = st_ff.por_cnt + 3'h1;
			end
			else
			begin
				nxt_st.por_done = 1'b1;
			end
		end

		// Power-on monitor switches off once the digital supply settles
		if (dig_supply_stable_i)
		begin
			nxt_st.por_mon_on = 1'b0;
		end
		if (st_ff.por_done && !st_ff.por_mon_on && !prec_dig)
		begin
			nxt_st.osc_en = 1'b1;
		end

		// Precise reset enables; digital side has no software switch
		nxt_st.prec_den = prec_on & ~st_ff.por_mon_on;
		nxt_st.prec_aen = prec_on & ~st_ff.por_mon_on & st_ff.ctrl[RSSUP_CTRL_ANAEN];

		// Combined reset: assert on the next edge, release only after every source is gone
		if (pulse_src)
		begin
			nxt_st.hold_cnt = RSSUP_HOLD_CYC;
		end
		else if (st_ff.hold_cnt != 3'h0)
		begin
			nxt_st.hold_cnt = st_ff.hold_cnt - 3'h1;
		end
		nxt_st.sys_rst = ~st_ff.por_done | level_src | pulse_src | (st_ff.hold_cnt > 3'h1);

		// Status survives every reset except power-on
		nxt_st.stat = (st_ff.stat & ~stat_clr) | stat_set;

		// Watchdog count, kick and sticky enable
		if (st_ff.sys_rst || !st_ff.wdog_en)
		begin
			nxt_st.wdog_cnt = '0;
		end
		else
		begin
			nxt_st.wdog_cnt = st_ff.wdog_cnt + 16'h0001;
		end
		if (bus_wr && paddr_i == RSSUP_WDCTL_OFS)
		begin
			if (pwdata_i[RSSUP_WD_EN])
			begin
				nxt_st.wdog_en = 1'b1;
			end
			if (pwdata_i[RSSUP_WD_KICK])
			begin
				nxt_st.wdog_cnt = '0;
			end
		end

		// Configuration writes
		if (bus_wr && paddr_i == RSSUP_CTRL_OFS)
		begin
			nxt_st.ctrl = pwdata_i[3:0];
		end
		if (bus_wr && paddr_i == RSSUP_MON_OFS)
		begin
			nxt_st.mon = pwdata_i[12:0];
		end
		if (bus_wr && paddr_i == RSSUP_WDPER_OFS)
		begin
			nxt_st.wdog_per = pwdata_i[15:0];
		end

		// System reset returns control, monitor and watchdog period settings to defaults
		if (st_ff.sys_rst)
		begin
			nxt_st.ctrl = RSSUP_CTRL_RST;
			nxt_st.mon = RSSUP_MON_RST;
			nxt_st.wdog_per = WDOG_PERIOD_RST;
		end

		// Monitor interrupt: wake first, present only once awake
		nxt_st.wake_req = sleep_i & |(st_ff.stat & RSSUP_IRQ_MASK);
		nxt_st.irq = ~sleep_i & ~hibernate_i & |(st_ff.stat & RSSUP_IRQ_MASK);

		// APB: one wait state, read data captured with pready
		nxt_st.pready = bus_rd_phase;
		nxt_st.pslverr = 1'b0;
		nxt_st.prdata = '0;
		if (bus_rd_phase)
		begin
			unique case (paddr_i)
				RSSUP_CTRL_OFS: nxt_st.prdata = {28'h0000000, st_ff.ctrl};
				RSSUP_MON_OFS: nxt_st.prdata = {19'h00000, st_ff.mon};
				RSSUP_STAT_OFS: nxt_st.prdata = {22'h000000, st_ff.stat};
				RSSUP_WDCTL_OFS: nxt_st.prdata = {31'h00000000, st_ff.wdog_en};
				RSSUP_WDPER_OFS: nxt_st.prdata = {16'h0000, st_ff.wdog_per};
				default: nxt_st.pslverr = 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers: only the power-on reset input clears everything

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_ff <= '0;
			st_ff.por_mon_on <= 1'b1;
			st_ff.sys_rst <= 1'b1;
			st_ff.ctrl <= RSSUP_CTRL_RST;
			st_ff.mon <= RSSUP_MON_RST;
			st_ff.wdog_per <= WDOG_PERIOD_RST;
			st_ff.wdog_en <= 1'b0;
			st_ff.stat <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata_o = st_ff.prdata;
	assign pready_o = st_ff.pready;
	assign pslverr_o = st_ff.pslverr;
	assign sys_reset_n_o = ~st_ff.sys_rst;
	assign por_mon_enable_o = st_ff.por_mon_on;
	assign prec_dig_enable_o = st_ff.prec_den;
	assign prec_ana_enable_o = st_ff.prec_aen;
	assign monitor_enable_o = st_ff.por_done;
	assign dig_low_level_o = st_ff.mon[RSSUP_MON_DLVL_LSB+:4];
	assign ana_low_level_o = st_ff.mon[RSSUP_MON_ALVL_LSB+:4];
	assign main_oscillator_en_o = st_ff.osc_en;
	assign wake_req_o = st_ff.wake_req;
	assign monitor_irq_o = st_ff.irq;
endmodule
